// *** sctc_chk_properties.sv ***
// assertions on the ports of the clock tree control
// assumes it is bound into sctc_top; one clock domain
module sctc_chk (
	// clock and reset
	input wire        clk,
	input wire        rst_n,
	// register bus
	input wire [3:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire        avs_waitrequest,
	// controls and clock enables
	input wire        deep_sleep,
	input wire        ring_osc_enable,
	input wire        pll_enable,
	input wire        pll_bypass,
	input wire [15:0] pll_config,
	input wire        frclk_en,
	input wire        sclk_en,
	input wire        aclk_en,
	input wire        hclk_en,
	input wire        pclk_en,
	input wire        pmclk_en
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	wire  wr_ok = avs_write & ~avs_waitrequest;
	logic hgate_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hgate_q <= 1'b0;
		else if (wr_ok && avs_address == 4'h0)
			hgate_q <= avs_writedata[7];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence req_new;
		(avs_read | avs_write) && !$past(avs_waitrequest);
	endsequence
	sequence acc_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	property one_cycle(s);
		s |=> !s;
	endproperty
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	bus_wait_a: assert property (req_new |-> acc_wait)
		else $error("access not answered after one wait cycle");
	ring_ctl_a: assert property ($changed(ring_osc_enable) |->
		$past(wr_ok && avs_address == 4'h0) &&
		ring_osc_enable == !$past(avs_writedata[0]))
		else $error("ring enable moved without a control write");
	pll_ctl_a: assert property ($changed({pll_bypass, pll_enable}) |->
		$past(wr_ok && avs_address == 4'h0) &&
		{pll_bypass, pll_enable} == $past(avs_writedata[5:4]))
		else $error("pll enable or bypass wrong");
	pll_cfg_a: assert property ($changed(pll_config) |->
		$past(wr_ok && avs_address == 4'h8) &&
		pll_config == $past(avs_writedata[15:0]))
		else $error("pll setting wrong");
	aclk_sleep_a: assert property (deep_sleep && $past(deep_sleep) |-> !aclk_en)
		else $error("auxiliary pulse in deep sleep");
	div_src_a: assert property (aclk_en || hclk_en |-> sclk_en)
		else $error("divider pulse without system pulse");
	pclk_src_a: assert property (pclk_en |-> $past(hclk_en))
		else $error("peripheral pulse not after bus pulse");
	hclk_gate_a: assert property (hgate_q && $past(hgate_q, 2) |->
		!hclk_en && !pclk_en)
		else $error("bus clock pulse while gated");
	fr_pulse_a: assert property (one_cycle(frclk_en))
		else $error("free-running pulse longer than one cycle");
	sys_pulse_a: assert property (one_cycle(sclk_en))
		else $error("system pulse longer than one cycle");
	pm_rate_a: assert property (pmclk_en |=> !pmclk_en [*8])
		else $error("power manager pulses too close");
endmodule // sctc_chk

bind sctc_top sctc_chk u_chk (
	.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.deep_sleep(deep_sleep), .ring_osc_enable(ring_osc_enable),
	.pll_enable(pll_enable), .pll_bypass(pll_bypass),
	.pll_config(pll_config), .frclk_en(frclk_en), .sclk_en(sclk_en),
	.aclk_en(aclk_en), .hclk_en(hclk_en), .pclk_en(pclk_en),
	.pmclk_en(pmclk_en));

// *** sctc_div.v ***
// 3-bit clock divider with gate, working on clock-enable pulses
// assumes tick_in is a one-cycle pulse on clk; div and gate_on are on clk
module sctc_div (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// control
	input  wire [2:0] div,
	input  wire       gate_on,
	// ticks
	input  wire       tick_in,
	output reg        tick_out
);

	reg [2:0] cnt_q;
	reg [2:0] cur_q;

	// new ratio taken only at wrap, so no period is ever cut short
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q    <= 3'h0;
			cur_q    <= 3'h0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (cnt_q == cur_q) begin // see RULE_18
					cnt_q    <= 3'h0;
					cur_q    <= div;
					tick_out <= gate_on;
				end else begin
					cnt_q <= cnt_q + 3'h1;
				end
			end
		end
	end

endmodule // sctc_div

// *** sctc_regs.vh ***
// register map, field positions and reset values of the clock tree control
// assumes byte addresses on a 32-bit avalon-mm slave, one word per register
`ifndef SCTC_REGS_VH
`define SCTC_REGS_VH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define SCTC_OFS_CTRL     4'h0
`define SCTC_OFS_DIV      4'h4
`define SCTC_OFS_PLLCFG   4'h8
`define SCTC_OFS_STATUS   4'hC

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define SCTC_CTRL_RING_OFF   0
`define SCTC_CTRL_FRSEL_LO   1
`define SCTC_CTRL_FRSEL_HI   2
`define SCTC_CTRL_SYS_PLL    3
`define SCTC_CTRL_PLL_EN     4
`define SCTC_CTRL_PLL_BYP    5
`define SCTC_CTRL_PCLK_OFF   6
`define SCTC_CTRL_HCLK_OFF   7
`define SCTC_CTRL_W          8
`define SCTC_CTRL_RST        8'h00

// free-running source codes
`define SCTC_FR_RING      2'h0
`define SCTC_FR_EXT       2'h1
`define SCTC_FR_REF       2'h2

// ----------------------------------------------------------------------
// divider fields, ratio is setting plus one
// ----------------------------------------------------------------------
`define SCTC_DIV_A_LO     0
`define SCTC_DIV_A_HI     2
`define SCTC_DIV_H_LO     4
`define SCTC_DIV_H_HI     6
`define SCTC_DIV_P_LO     8
`define SCTC_DIV_P_HI     10
`define SCTC_DIV_RST      11'h000

// ----------------------------------------------------------------------
// pll configuration and status
// ----------------------------------------------------------------------
`define SCTC_PLLCFG_W     16
`define SCTC_PLLCFG_RST   16'h0000
`define SCTC_ST_LOCK      0
`define SCTC_ST_FR_LO     1
`define SCTC_ST_FR_HI     2
`define SCTC_ST_SYS_PLL   3
`define SCTC_ST_RING_ON   4
`define SCTC_ST_BUSY      5

`endif

// *** sctc_src_model.sv ***
// far side: clock source pins and pll lock indication
// assumes each pin level lasts well over two block clock cycles
module sctc_src_model #(
	parameter int LOCK_NS = 2000
) (
	// controls from the block
	input  wire  ring_osc_enable,
	input  wire  pll_enable,
	// pins
	output logic ring_osc_clock,
	output logic ext_clock,
	output logic ref_clock,
	output logic pll_output_clock,
	output logic pll_locked_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ring_osc_clock = 1'b0;
		ext_clock = 1'b0;
		ref_clock = 1'b0;
		pll_output_clock = 1'b0;
		pll_locked_flag = 1'b0;
	end
	// stopped oscillators rest low
	// pins move by non-blocking assignment: an edge that lands on a
	// block clock edge is seen one cycle later, never raced
	always #100
		ring_osc_clock <= ring_osc_enable & ~ring_osc_clock;
	always #140 ext_clock <= ~ext_clock;
	always #180 ref_clock <= ~ref_clock;
	always #120
		pll_output_clock <= pll_enable & ~pll_output_clock;
	always @(posedge pll_enable) begin
		#(LOCK_NS);
		pll_locked_flag <= pll_enable;
	end
	always @(negedge pll_enable) pll_locked_flag <= 1'b0;
endmodule // sctc_src_model

// *** sctc_top.v ***
// clock tree control: source select, pll control, dividers and gates
// assumes clock pins are slow against clk; every derived clock leaves
// as a one-cycle enable pulse on clk, registers sit on avalon-mm
//
// Notes on behaviour
// RULE_01: reset selects ring oscillator, system from it
// RULE_02: software can switch the ring oscillator off
// RULE_03: free-running clock picks ring, external or reference
// RULE_04: free-running tick feeds watchdog and rtc always
// RULE_05: software uses external or reference for pll
// RULE_06: software keeps pll input and output in range
// RULE_07: software mux picks pll or free-running as system
// RULE_08: software enables, disables or bypasses the pll
// RULE_09: auxiliary and bus clocks have own 3-bit dividers
// RULE_10: peripheral clock has 3-bit divider and gate
// RULE_11: auxiliary clock gated off in deep sleep
// RULE_12: auxiliary clock goes only to pwm timer
// RULE_13: bus clock has 3-bit divider and gate
// RULE_14: peripheral divider fed from bus clock
// RULE_15: reference selectable, also clocks power manager
// RULE_16: external clock at most 20 mhz, half duty
// RULE_17: pll lock flag readable in status
// RULE_18: switching and divider changes never truncate pulses
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`include "sctc_regs.vh"

module sctc_top #(
	parameter       SWITCH_TIMEOUT = 64,
	parameter [2:0] PM_DIV         = 3'h3
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// avalon-mm slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// processor state
	input  wire        deep_sleep,
	// clock source and pll pins
	input  wire        ring_osc_clock,
	input  wire        ext_clock,
	input  wire        ref_clock,
	input  wire        pll_output_clock,
	input  wire        pll_locked_flag,
	// analog controls
	output wire        ring_osc_enable,
	output wire        pll_enable,
	output wire        pll_bypass,
	output wire [15:0] pll_config,
	// clock enables
	output reg         frclk_en,
	output reg         sclk_en,
	output wire        aclk_en,
	output wire        hclk_en,
	output wire        pclk_en,
	output wire        pmclk_en
);

	localparam NPIN = 5;
	localparam [7:0] TMO = SWITCH_TIMEOUT[7:0];

	// switch states
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_FR   = 2'h1;
	localparam [1:0] ST_SYS  = 2'h2;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	// sampling at 25 mhz aliases a 20 mhz source; ticks then show the
	// beat, not the true rate, a limitation of this cycle-based model
	wire [NPIN-1:0] pin_raw;
	reg  [NPIN-1:0] sync1_q;
	reg  [NPIN-1:0] sync2_q;
	reg  [NPIN-1:0] sync3_q;
	wire [NPIN-1:0] pin_tick;

	assign pin_raw = {pll_locked_flag, pll_output_clock, ref_clock,
		ext_clock, ring_osc_clock};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
				end
			end
			assign pin_tick[gi] = sync2_q[gi] & ~sync3_q[gi];
		end
	endgenerate

	wire ring_tick = pin_tick[0];
	wire ext_tick  = pin_tick[1];
	wire ref_tick  = pin_tick[2];
	wire pll_tick  = pin_tick[3];
	wire pll_lock  = sync2_q[4];

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	reg  [`SCTC_CTRL_W-1:0]   ctrl_q;
	reg  [`SCTC_DIV_P_HI:0]    div_q;
	reg  [`SCTC_PLLCFG_W-1:0] pllcfg_q;
	reg                       ack_q;

	wire req     = avs_read | avs_write;
	wire wr_take = avs_write & ack_q;

	// one wait cycle: data are latched first, answered on the next edge
	assign avs_waitrequest = req & ~ack_q;

	wire       ring_off = ctrl_q[`SCTC_CTRL_RING_OFF];
	wire [1:0] fr_sel   = ctrl_q[`SCTC_CTRL_FRSEL_HI:`SCTC_CTRL_FRSEL_LO];
	wire       sys_pll  = ctrl_q[`SCTC_CTRL_SYS_PLL];
	wire       pclk_off = ctrl_q[`SCTC_CTRL_PCLK_OFF];
	wire       hclk_off = ctrl_q[`SCTC_CTRL_HCLK_OFF];

	assign ring_osc_enable = ~ring_off; // see RULE_02
	assign pll_enable      = ctrl_q[`SCTC_CTRL_PLL_EN]; // see RULE_08
	assign pll_bypass      = ctrl_q[`SCTC_CTRL_PLL_BYP]; // see RULE_08
	assign pll_config      = pllcfg_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q   <= `SCTC_CTRL_RST; // see RULE_01
			div_q    <= `SCTC_DIV_RST;
			pllcfg_q <= `SCTC_PLLCFG_RST;
		end else if (wr_take) begin
			case (avs_address)
				`SCTC_OFS_CTRL:   ctrl_q   <= avs_writedata[`SCTC_CTRL_W-1:0];
				`SCTC_OFS_DIV:    div_q    <=
					avs_writedata[`SCTC_DIV_P_HI:0];
				`SCTC_OFS_PLLCFG: pllcfg_q <=
					avs_writedata[`SCTC_PLLCFG_W-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// source switching
	// ------------------------------------------------------------------
	reg [1:0] state_q;
	reg [1:0] act_fr_q;
	reg       act_pll_q;
	reg [7:0] wto_q;
	reg       fr_raw;
	wire      fr_tick;
	wire      pll_path;
	wire      sys_tick;

	// ring ticks are ignored while the oscillator is off
	always @* begin
		case (act_fr_q) // see RULE_03
			`SCTC_FR_RING: fr_raw = ring_tick & ~ring_off;
			`SCTC_FR_EXT:  fr_raw = ext_tick;
			`SCTC_FR_REF:  fr_raw = ref_tick; // see RULE_15
			default:       fr_raw = 1'b0;
		endcase
	end

	// a switch can put the last old tick right before a first new one;
	// two enables back to back would be a cut period, so a tick that
	// follows a pulse directly is dropped
	assign fr_tick  = fr_raw & ~frclk_en; // see RULE_18
	assign pll_path = pll_enable & (pll_bypass ? fr_tick : pll_tick);
	assign sys_tick = ~sclk_en & // see RULE_07
		(act_pll_q ? pll_path : fr_tick);

	// commit a change only right after a tick of the old source, so the
	// last period runs whole; timeout covers a source that has stopped
	wire wto_end = (wto_q == TMO);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= ST_IDLE;
			act_fr_q  <= `SCTC_FR_RING; // see RULE_01
			act_pll_q <= 1'b0;
			wto_q     <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					wto_q <= 8'h00;
					if (fr_sel != act_fr_q)
						state_q <= ST_FR;
					else if (sys_pll != act_pll_q)
						state_q <= ST_SYS;
				end
				ST_FR: begin
					wto_q <= wto_q + 8'h01;
					if (fr_tick | wto_end) begin // see RULE_18
						act_fr_q <= fr_sel;
						state_q  <= ST_IDLE;
					end
				end
				ST_SYS: begin
					wto_q <= wto_q + 8'h01;
					if (sys_tick | wto_end) begin // see RULE_18
						act_pll_q <= sys_pll;
						state_q   <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// free-running and system enables
	// ------------------------------------------------------------------
	// frclk never passes a gate, so watchdog and rtc run in deep sleep
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frclk_en <= 1'b0;
			sclk_en  <= 1'b0;
		end else begin
			frclk_en <= fr_tick; // see RULE_04
			sclk_en  <= sys_tick;
		end
	end

	// ------------------------------------------------------------------
	// dividers and gates
	// ------------------------------------------------------------------
	// auxiliary: leaves only on aclk_en, meant for the pwm timer alone
	sctc_div u_aclk (
		.clk      (clk),
		.rst_n    (rst_n),
		.div      (div_q[`SCTC_DIV_A_HI:`SCTC_DIV_A_LO]), // see RULE_09
		.gate_on  (~deep_sleep), // see RULE_11
		.tick_in  (sys_tick), // see RULE_12
		.tick_out (aclk_en)
	);

	sctc_div u_hclk (
		.clk      (clk),
		.rst_n    (rst_n),
		.div      (div_q[`SCTC_DIV_H_HI:`SCTC_DIV_H_LO]), // see RULE_09
		.gate_on  (~hclk_off), // see RULE_13
		.tick_in  (sys_tick),
		.tick_out (hclk_en)
	);

	sctc_div u_pclk (
		.clk      (clk),
		.rst_n    (rst_n),
		.div      (div_q[`SCTC_DIV_P_HI:`SCTC_DIV_P_LO]), // see RULE_10
		.gate_on  (~pclk_off), // see RULE_10
		.tick_in  (hclk_en), // see RULE_14
		.tick_out (pclk_en)
	);

	// power manager clock always comes from the reference oscillator
	sctc_div u_pmclk (
		.clk      (clk),
		.rst_n    (rst_n),
		.div      (PM_DIV),
		.gate_on  (1'b1),
		.tick_in  (ref_tick), // see RULE_15
		.tick_out (pmclk_en)
	);

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			`SCTC_OFS_CTRL:   rd_mux[`SCTC_CTRL_W-1:0] = ctrl_q;
			`SCTC_OFS_DIV:    rd_mux[`SCTC_DIV_P_HI:0] = div_q;
			`SCTC_OFS_PLLCFG: rd_mux[`SCTC_PLLCFG_W-1:0] = pllcfg_q;
			`SCTC_OFS_STATUS: begin
				rd_mux[`SCTC_ST_LOCK]    = pll_lock; // see RULE_17
				rd_mux[`SCTC_ST_FR_HI:`SCTC_ST_FR_LO] = act_fr_q;
				rd_mux[`SCTC_ST_SYS_PLL] = act_pll_q;
				rd_mux[`SCTC_ST_RING_ON] = ~ring_off;
				rd_mux[`SCTC_ST_BUSY]    = (state_q != ST_IDLE);
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (avs_read & ~ack_q)
				avs_readdata <= rd_mux;
		end
	end

endmodule // sctc_top

// *** tb_system_clock_tree_control.sv ***
// self-checking bench for the clock tree control
// assumes sctc_src_model drives the source pins
module tb_system_clock_tree_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic        sleep = 1'b0;
	wire  [31:0] rdata;
	wire  [15:0] cfg;
	wire         wreq, ring_en, pll_en, byp, fr, sc, ac, hc, pc, pm;
	wire         rclk, eclk, fclk, pclk_pin, lock;
	int          n_mismatch = 0;
	int          compares = 0;
	sctc_top #(.SWITCH_TIMEOUT(4)) dut (
		.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .deep_sleep(sleep),
		.ring_osc_clock(rclk), .ext_clock(eclk), .ref_clock(fclk),
		.pll_output_clock(pclk_pin), .pll_locked_flag(lock),
		.ring_osc_enable(ring_en), .pll_enable(pll_en), .pll_bypass(byp),
		.pll_config(cfg), .frclk_en(fr), .sclk_en(sc), .aclk_en(ac),
		.hclk_en(hc), .pclk_en(pc), .pmclk_en(pm));
	sctc_src_model src (.ring_osc_enable(ring_en), .pll_enable(pll_en),
		.ring_osc_clock(rclk), .ext_clock(eclk), .ref_clock(fclk),
		.pll_output_clock(pclk_pin), .pll_locked_flag(lock));
	always #20 clk = ~clk;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// request stands until waitrequest is seen low at a rising edge;
	// one more edge lets the written value settle before any check
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return fr;
			1: return sc;
			2: return ac;
			3: return hc;
			4: return pc;
			default: return pm;
		endcase
	endfunction
	task automatic cnt(output int k[6]);
		k = '{default:0};
		repeat (5) @(negedge clk);
		repeat (100) begin
			@(negedge clk);
			foreach (k[i]) k[i] += (pick(i) === 1'b1);
		end
	endtask
	// base pulses between two target pulses
	task automatic gap(input int b, t, output int g);
		g = 0;
		do @(negedge clk); while (pick(t) !== 1'b1);
		do begin
			@(negedge clk);
			g += (pick(b) === 1'b1);
		end while (pick(t) !== 1'b1);
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [1:0]  src[3] = '{2'h1, 2'h2, 2'h0};
		int          g;
		int          k[6];
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		chk("ring_en", ring_en, 32'h1);
		bus(0, 4'hC, 32'h0, q);
		chk("status", q, 32'h10);
		bus(1, 4'h4, 32'hFFFFFFFF, q);
		bus(0, 4'h4, 32'h0, q);
		chk("div", q, 32'h7FF);
		bus(1, 4'h2, 32'hFFFF, q);
		bus(0, 4'h2, 32'h0, q);
		chk("unmapped", q, 32'h0);
		bus(1, 4'h4, 32'h121, q);
		gap(1, 2, g);
		chk("aclk_ratio", g, 32'h2);
		gap(1, 3, g);
		chk("hclk_ratio", g, 32'h3);
		gap(3, 4, g);
		chk("pclk_ratio", g, 32'h2);
		bus(1, 4'h0, 32'h80, q);
		sleep <= 1'b1;
		cnt(k);
		chk("fr_run", k[0] > 0, 32'h1);
		chk("aclk_sleep", k[2], 32'h0);
		chk("hclk_gate", k[3], 32'h0);
		chk("pclk_via_h", k[4], 32'h0);
		chk("pm_run", k[5] > 0, 32'h1);
		sleep <= 1'b0;
		bus(1, 4'h0, 32'h40, q);
		cnt(k);
		chk("pclk_gate", k[4], 32'h0);
		chk("hclk_run", k[3] > 0, 32'h1);
		chk("aclk_run", k[2] > 0, 32'h1);
		foreach (src[i]) begin
			bus(1, 4'h0, {29'h0, src[i], 1'b0}, q);
			repeat (20) @(posedge clk);
			bus(0, 4'hC, 32'h0, q);
			chk("fr_src", q, {27'h2, src[i], 1'b0});
			if (src[i] == 2'h2) begin
				gap(0, 5, g);
				chk("pm_ratio", g, 32'h4);
			end
		end
		bus(1, 4'h8, 32'h1234A5C3, q);
		chk("pll_cfg", cfg, 32'hA5C3);
		bus(1, 4'hC, 32'hFFFFFFFF, q);
		bus(0, 4'hC, 32'h0, q);
		chk("status_ro", q, 32'h10);
		bus(1, 4'h0, 32'h14, q);
		chk("pll_en", pll_en, 32'h1);
		do bus(0, 4'hC, 32'h0, q); while (q[0] !== 1'b1);
		bus(1, 4'h0, 32'h1C, q);
		repeat (20) @(posedge clk);
		bus(0, 4'hC, 32'h0, q);
		chk("sys_pll", q, 32'h1D);
		bus(1, 4'h0, 32'h3C, q);
		chk("bypass", byp, 32'h1);
		bus(1, 4'h0, 32'h05, q);
		repeat (20) @(posedge clk);
		bus(0, 4'hC, 32'h0, q);
		chk("ring_off", q, 32'h04);
		chk("ring_pin", ring_en, 32'h0);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, 4'h0, 32'h0, q);
		chk("ctrl_rst", q, 32'h0);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule // tb_system_clock_tree_control
